//--- logic/cpf_pkg.sv
package cpf_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
  // times in microseconds
  localparam int unsigned PERIOD_US = 1_000_000;
  localparam int unsigned WIN_US = 1000;
  localparam int unsigned HALF_US = 500;
  localparam int unsigned OC_DELAY_US = 3000;
  localparam int unsigned PERIOD_CYC = PERIOD_US * CYC_PER_US;
  localparam int unsigned WIN_CYC = WIN_US * CYC_PER_US;
  localparam int unsigned HALF_CYC = HALF_US * CYC_PER_US;
  localparam int unsigned OC_CYC = OC_DELAY_US * CYC_PER_US;
  localparam logic [1:0] UV_TRIP = 2'h2;
  // register map, byte addresses
  localparam logic [3:0] CTRL_ADDR = 4'h0;
  localparam logic [3:0] STATUS_ADDR = 4'h4;
  localparam logic [3:0] IRQ_STAT_ADDR = 4'h8;
  localparam logic [3:0] IRQ_MASK_ADDR = 4'hC;
  localparam int CTRL_THSEL_BIT = 0;
  localparam logic CTRL_RESET = 1'h0;
  localparam logic [3:0] IRQ_MASK_RESET = 4'h0;
  localparam int EV_OV = 0;
  localparam int EV_UV = 1;
  localparam int EV_OC = 2;
  localparam int EV_CLR = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_OV = 2'b01,
    S_UV = 2'b10,
    S_SLEEP = 2'b11
  } cpf_state_t;
endpackage

//--- logic/cpf_fault_logic.sv
`timescale 1ns/1ps
// Function
// - sample switch on 1.0 ms each second
// - overvoltage test first half, undervoltage second
// - failed overvoltage test sets a fault latch
// - overvoltage fault: charge off, discharge on
// - hysteresis enable follows overvoltage fault
// - below hysteresis clears overvoltage, charge on
// - third consecutive undervoltage: discharge off, sleep
// - passing sample resets undervoltage count
// - charger presence clears undervoltage, discharge on
// - overcurrent latches fault, discharge off
// - overcurrent must persist 3.0 ms first
// - overcurrent clears once sense drops below threshold
// - overcurrent detection disabled during overvoltage
// - test input low resets logic, switches on
module cpf_fault_logic import cpf_pkg::*; #(
  parameter int unsigned PERIOD = PERIOD_CYC,
  parameter int unsigned WIN = WIN_CYC,
  parameter int unsigned HALF = HALF_CYC,
  parameter int unsigned OCDLY = OC_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic testPin_n,
  input wire logic limitCmp,
  input wire logic chargerCmp,
  input wire logic overcurrentCmp,
  output logic sampleSwitch,
  output logic ovTapSelect,
  output logic hystEnable,
  output logic charge_path_switch,
  output logic discharge_path_switch,
  output logic overcurrent_sense_threshold,
  output logic sleepMode,
  output logic irq,
  input wire logic [3:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [3:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  if (HALF < 1 || WIN != 2 * HALF || PERIOD <= WIN || OCDLY < 1) begin
    $error("cpf_fault_logic: bad timing parameters");
  end

  // pin synchronisers; only stage 2 is read by logic
  logic [3:0] sync1, sync2;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1 <= 4'h1;
      sync2 <= 4'h1;
    end else begin
      sync1 <= {overcurrentCmp, chargerCmp, limitCmp, testPin_n};
      sync2 <= sync1;
    end
  end
  logic testS, limS, chgS, ocS;
  assign {ocS, chgS, limS, testS} = sync2;

  // protection core
  cpf_state_t state, next_state;
  logic [31:0] cnt, next_cnt, ocTimer, next_ocTimer;
  logic [1:0] uvCnt, next_uvCnt;
  logic ovFault, uvFault, ocFault, next_ovFault, next_uvFault, next_ocFault;
  logic [3:0] ev;
  logic ovSample, uvSample, thSel;

  always_comb begin
    next_state = state;
    next_cnt = cnt + 32'h1;
    next_uvCnt = uvCnt;
    next_ovFault = ovFault;
    next_uvFault = uvFault;
    next_ocFault = ocFault;
    next_ocTimer = 32'h0;
    ev = 4'h0;
    ovSample = (state == S_OV) && (cnt == HALF - 1);
    uvSample = (state == S_UV) && (cnt == WIN - 1);
    if (cnt == PERIOD - 1) next_cnt = 32'h0;
    case (state)
      S_IDLE: if (cnt == PERIOD - 1) next_state = S_OV;
      S_OV: if (ovSample) next_state = S_UV;
      S_UV: if (uvSample) next_state = S_IDLE;
      S_SLEEP: next_cnt = 32'h0;
      default: next_state = S_IDLE;
    endcase
    // with the pull-up active the same tap reads the hysteresis level
    if (ovSample && limS && !ovFault) begin
      next_ovFault = 1'b1;
      ev[EV_OV] = 1'b1;
    end else if (ovSample && !limS && ovFault) begin
      next_ovFault = 1'b0;
      ev[EV_CLR] = 1'b1;
    end
    if (uvSample && !limS) begin
      next_uvCnt = 2'h0;
    end else if (uvSample && uvCnt == UV_TRIP) begin
      next_uvFault = 1'b1;
      next_uvCnt = 2'h0;
      next_state = S_SLEEP;
      ev[EV_UV] = 1'b1;
    end else if (uvSample) begin
      next_uvCnt = uvCnt + 2'h1;
    end
    if (uvFault && chgS) begin
      next_uvFault = 1'b0;
      next_state = S_OV;
      next_cnt = 32'h0;
      ev[EV_CLR] = 1'b1;
    end
    // off charge switch would look like overcurrent, so no detection
    if (ocFault && !ocS) begin
      next_ocFault = 1'b0;
      ev[EV_CLR] = 1'b1;
    end else if (!ocFault && ocS && !ovFault) begin
      next_ocTimer = ocTimer + 32'h1;
      if (ocTimer == OCDLY - 1) begin
        next_ocFault = 1'b1;
        next_ocTimer = 32'h0;
        ev[EV_OC] = 1'b1;
      end
    end
    if (!testS) begin
      next_state = S_OV;
      next_cnt = 32'h0;
      next_uvCnt = 2'h0;
      next_ovFault = 1'b0;
      next_uvFault = 1'b0;
      next_ocFault = 1'b0;
      next_ocTimer = 32'h0;
      ev = 4'h0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= S_IDLE;
      cnt <= 32'(PERIOD - 1);
      uvCnt <= 2'h0;
      ovFault <= 1'b0;
      uvFault <= 1'b0;
      ocFault <= 1'b0;
      ocTimer <= 32'h0;
      sampleSwitch <= 1'b0;
      ovTapSelect <= 1'b0;
      hystEnable <= 1'b0;
      charge_path_switch <= 1'b1;
      discharge_path_switch <= 1'b1;
      sleepMode <= 1'b0;
      overcurrent_sense_threshold <= CTRL_RESET;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      uvCnt <= next_uvCnt;
      ovFault <= next_ovFault;
      uvFault <= next_uvFault;
      ocFault <= next_ocFault;
      ocTimer <= next_ocTimer;
      sampleSwitch <= (next_state == S_OV) || (next_state == S_UV);
      ovTapSelect <= next_state == S_OV;
      hystEnable <= next_ovFault;
      charge_path_switch <= !next_ovFault;
      discharge_path_switch <= !(next_uvFault || next_ocFault);
      sleepMode <= next_state == S_SLEEP;
      overcurrent_sense_threshold <= thSel;
    end
  end

  // AXI4-Lite slave; one write and one read in flight
  logic awHeld, wHeld, next_awHeld, next_wHeld;
  logic [3:0] awAddr, next_awAddr;
  logic [31:0] wDat, next_wDat, next_rdata;
  logic wStb, next_wStb, next_thSel, next_bvalid, next_rvalid, doWrite;
  logic [1:0] next_bresp, next_rresp;
  logic [3:0] irqStat, irqMask, next_irqStat, next_irqMask;

  always_comb begin
    next_awHeld = awHeld;
    next_wHeld = wHeld;
    next_awAddr = awAddr;
    next_wDat = wDat;
    next_wStb = wStb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rresp = rresp;
    next_rdata = rdata;
    next_thSel = thSel;
    next_irqMask = irqMask;
    next_irqStat = irqStat;
    if (awvalid && awready) begin
      next_awHeld = 1'b1;
      next_awAddr = awaddr;
    end
    if (wvalid && wready) begin
      next_wHeld = 1'b1;
      next_wDat = wdata;
      next_wStb = wstrb[0];
    end
    doWrite = awHeld && wHeld && !bvalid;
    if (doWrite) begin
      next_awHeld = 1'b0;
      next_wHeld = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = RESP_OKAY;
      case (awAddr)
        CTRL_ADDR: if (wStb) next_thSel = wDat[CTRL_THSEL_BIT];
        IRQ_MASK_ADDR: if (wStb) next_irqMask = wDat[3:0];
        STATUS_ADDR, IRQ_STAT_ADDR: ;
        default: next_bresp = RESP_SLVERR;
      endcase
    end
    if (bvalid && bready) next_bvalid = 1'b0;
    if (rvalid && rready) next_rvalid = 1'b0;
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      next_rdata = 32'h0;
      case (araddr)
        CTRL_ADDR: next_rdata[CTRL_THSEL_BIT] = thSel;
        STATUS_ADDR: next_rdata[8:0] = {uvCnt, state == S_SLEEP,
          ocFault, uvFault, ovFault, hystEnable,
          discharge_path_switch, charge_path_switch};
        IRQ_STAT_ADDR: begin
          next_rdata[3:0] = irqStat;
          next_irqStat = 4'h0;
        end
        IRQ_MASK_ADDR: next_rdata[3:0] = irqMask;
        default: next_rresp = RESP_SLVERR;
      endcase
    end
    // an event in the clearing cycle survives the read
    next_irqStat = next_irqStat | ev;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= 4'h0;
      wDat <= 32'h0;
      wStb <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      arready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      rvalid <= 1'b0;
      rresp <= RESP_OKAY;
      rdata <= 32'h0;
      thSel <= CTRL_RESET;
      irqMask <= IRQ_MASK_RESET;
      irqStat <= 4'h0;
      irq <= 1'b0;
    end else begin
      awHeld <= next_awHeld;
      wHeld <= next_wHeld;
      awAddr <= next_awAddr;
      wDat <= next_wDat;
      wStb <= next_wStb;
      awready <= !next_awHeld && !next_bvalid;
      wready <= !next_wHeld && !next_bvalid;
      arready <= !next_rvalid;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
      thSel <= next_thSel;
      irqMask <= next_irqMask;
      irqStat <= next_irqStat;
      irq <= |(next_irqStat & next_irqMask);
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence uvThird_s;
    uvSample && limS && uvCnt == UV_TRIP && testS;
  endsequence
  sequence ocLong_s;
    ocTimer == OCDLY - 1 && ocS && !ovFault && !ocFault && testS;
  endsequence

  winHold_a: assert property ($rose(sampleSwitch) |-> sampleSwitch[*8])
    else $error("sample window too short");
  winOff_a: assert property (sleepMode |-> !sampleSwitch)
    else $error("sampling during sleep");
  phaseOrder_a: assert property (
    $fell(ovTapSelect) && testS |-> sampleSwitch)
    else $error("undervoltage half missing");
  ovSet_a: assert property (
    ovSample && limS && testS |=> ovFault && !charge_path_switch)
    else $error("overvoltage not latched");
  ovSwitch_a: assert property (ovFault && !uvFault && !ocFault
    |-> !charge_path_switch && discharge_path_switch && hystEnable)
    else $error("overvoltage switch state wrong");
  ovClear_a: assert property (ovSample && !limS && ovFault && testS
    |=> !ovFault && charge_path_switch && !hystEnable)
    else $error("overvoltage not cleared");
  uvTrip_a: assert property (
    uvThird_s |=> uvFault && !discharge_path_switch && sleepMode)
    else $error("third undervoltage ignored");
  uvReset_a: assert property (
    uvSample && !limS |=> uvCnt == 2'h0 && !$rose(uvFault))
    else $error("undervoltage count kept");
  uvClear_a: assert property (
    uvFault && chgS && testS |=> !uvFault && !sleepMode)
    else $error("charger did not clear undervoltage");
  ocDelay_a: assert property (
    $rose(ocFault) |-> $past(ocTimer) == OCDLY - 1)
    else $error("overcurrent delay wrong");
  ocSet_a: assert property (ocLong_s |=> ocFault &&
    !discharge_path_switch)
    else $error("overcurrent not latched");
  ocClear_a: assert property (
    ocFault && !ocS && testS |=> !ocFault)
    else $error("overcurrent not cleared");
  ocBlock_a: assert property (ovFault |=> ocTimer == 32'h0)
    else $error("overcurrent timed during overvoltage");
  testRst_a: assert property (!testS |=> state == S_OV
      && cnt == 32'h0 && charge_path_switch && discharge_path_switch)
    else $error("test reset ineffective");
endmodule

//--- bench/cpf_cell_model.sv
`timescale 1ns/1ps
// shared cell comparator seen through the sample switch
module cpf_cell_model (
  input wire logic clk,
  input wire logic sampleSwitch,
  input wire logic ovTapSelect,
  input wire logic cellHigh,
  input wire logic cellLow,
  output logic limitCmp
);
  logic noise = 1'h0;
  // unpowered divider gives no valid result, so never hold a clean level
  always @(posedge clk) noise <= ~noise;
  always_comb begin
    if (sampleSwitch !== 1'h1) begin
      limitCmp = noise;
    end else if (ovTapSelect) begin
      // cellHigh: above the active level, limit or hysteresis
      limitCmp = cellHigh;
    end else begin
      limitCmp = cellLow;
    end
  end
endmodule

//--- bench/test_cell_protection_fault_logic.sv
`timescale 1ns/1ps
module test_cell_protection_fault_logic;
  import cpf_pkg::*;
  localparam int PER = 100;
  localparam int WN = 20;
  localparam int HF = 10;
  localparam int OCD = 16;
  logic clk = 1'h0, nrst = 1'h0, testPin_n = 1'h1, chargerCmp = 1'h0;
  logic overcurrentCmp = 1'h0, cellHigh = 1'h0, cellLow = 1'h0, limitCmp;
  logic sampleSwitch, ovTapSelect, hystEnable, sleepMode, irq;
  logic charge_path_switch, discharge_path_switch;
  logic overcurrent_sense_threshold, awready, wready, bvalid, arready;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0, rvalid;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [1:0] bresp, rresp, rs;
  int err_total = 0, checks = 0, cyc = 0, ns, no;

  cpf_fault_logic #(.PERIOD(PER), .WIN(WN), .HALF(HF), .OCDLY(OCD)) DUT (
    .clk, .nrst, .testPin_n, .limitCmp, .chargerCmp, .overcurrentCmp,
    .sampleSwitch, .ovTapSelect, .hystEnable, .charge_path_switch,
    .discharge_path_switch, .overcurrent_sense_threshold, .sleepMode,
    .irq, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready);
  cpf_cell_model MODEL (.clk, .sampleSwitch, .ovTapSelect, .cellHigh,
    .cellLow, .limitCmp);

  always #5 clk = ~clk;
  // whole run is near 1500 cycles; generous ceiling
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      err_total = err_total + 1;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("errors %0d checks %0d", err_total, checks);
    if (err_total == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask

  task automatic wt(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask

  // ready and valid are registered, so the negedge view equals the edge
  task automatic axw(input logic [3:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'h1;
    wdata <= d;
    wvalid <= 1'h1;
    wstrb <= 4'hF;
    bready <= 1'h1;
    tb = 1'h0;
    while (!tb) begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bready && bvalid;
      rs = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
      if (tb) bready <= 1'h0;
    end
  endtask

  task automatic axr(input logic [3:0] a);
    logic ta, tb;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    tb = 1'h0;
    while (!tb) begin
      @(negedge clk);
      ta = arvalid && arready;
      tb = rready && rvalid;
      rd = rdata;
      rs = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'h0;
      if (tb) rready <= 1'h0;
    end
  endtask

  task automatic cnt_win();
    ns = 0;
    no = 0;
    repeat (PER) begin
      @(negedge clk);
      ns += (sampleSwitch === 1'h1);
      no += (sampleSwitch === 1'h1 && ovTapSelect === 1'h1);
    end
  endtask

  task automatic t_bus();
    axw(CTRL_ADDR, 32'h1);
    chk(rs, RESP_OKAY, "ctrl write");
    wt(1);
    chk(overcurrent_sense_threshold, 1'h1, "threshold select");
    axr(CTRL_ADDR);
    chk(rd, 32'h1, "ctrl readback");
    axr(STATUS_ADDR);
    chk(rd, 32'h3, "status after reset");
    axr(4'h2);
    chk(rs, RESP_SLVERR, "unmapped read");
    axw(IRQ_MASK_ADDR, 32'h1);
  endtask

  task automatic t_ov();
    @(posedge clk) cellHigh <= 1'h1;
    wt(2 * PER);
    chk(charge_path_switch, 1'h0, "ov charge off");
    chk(discharge_path_switch, 1'h1, "ov discharge on");
    chk(hystEnable, 1'h1, "ov hysteresis");
    chk(irq, 1'h1, "ov irq");
    axr(IRQ_STAT_ADDR);
    chk(rd[0], 1'h1, "ov event bit");
    wt(2);
    chk(irq, 1'h0, "irq cleared by read");
    @(posedge clk) overcurrentCmp <= 1'h1;
    wt(3 * OCD);
    chk(discharge_path_switch, 1'h1, "oc masked in ov");
    @(posedge clk) overcurrentCmp <= 1'h0;
    @(posedge clk) testPin_n <= 1'h0;
    wt(4);
    chk(charge_path_switch, 1'h1, "test hold charge on");
    chk(hystEnable, 1'h0, "test hold no hyst");
    @(posedge clk) testPin_n <= 1'h1;
    wt(WN + 6);
    chk(charge_path_switch, 1'h0, "sample after test");
    @(posedge clk) cellHigh <= 1'h0;
    wt(2 * PER);
    chk(charge_path_switch, 1'h1, "ov cleared");
    chk(hystEnable, 1'h0, "hyst removed");
  endtask

  task automatic t_oc();
    @(posedge clk) overcurrentCmp <= 1'h1;
    wt(OCD - 4);
    @(posedge clk) overcurrentCmp <= 1'h0;
    wt(6);
    chk(discharge_path_switch, 1'h1, "short pulse ignored");
    @(posedge clk) overcurrentCmp <= 1'h1;
    wt(OCD + 6);
    chk(discharge_path_switch, 1'h0, "oc discharge off");
    chk(charge_path_switch, 1'h1, "oc charge on");
    @(posedge clk) overcurrentCmp <= 1'h0;
    wt(6);
    chk(discharge_path_switch, 1'h1, "oc cleared");
  endtask

  task automatic t_uv();
    // align just after a window so each span holds a known sample count
    while (sampleSwitch !== 1'h1) wt(1);
    while (sampleSwitch === 1'h1) wt(1);
    @(posedge clk) cellLow <= 1'h1;
    wt(2 * PER);
    @(posedge clk) cellLow <= 1'h0;
    wt(PER);
    @(posedge clk) cellLow <= 1'h1;
    wt(2 * PER);
    chk(discharge_path_switch, 1'h1, "uv count restarted");
    wt(PER + 10);
    chk(discharge_path_switch, 1'h0, "uv discharge off");
    chk(sleepMode, 1'h1, "uv sleep");
    chk(charge_path_switch, 1'h1, "uv charge on");
    cnt_win();
    chk(ns, 0, "no sampling in sleep");
    chk(discharge_path_switch, 1'h0, "sleep discharge off");
    @(posedge clk) begin
      chargerCmp <= 1'h1;
      cellLow <= 1'h0;
    end
    wt(6);
    chk(discharge_path_switch, 1'h1, "charger clears uv");
    chk(sleepMode, 1'h0, "sleep left");
    @(posedge clk) chargerCmp <= 1'h0;
  endtask

  initial begin
    wt(2);
    @(posedge clk) nrst <= 1'h1;
    cnt_win();
    chk(ns, WN, "window length");
    chk(no, HF, "ov half length");
    t_bus();
    t_ov();
    t_oc();
    t_uv();
    stop_test();
  end
endmodule
